// [design/mux_adc_host_interface.sv]
/*
 * digital control of an 8-bit successive approximation converter with a
 * four input multiplexer and a microprocessor style strobe interface.
 * assumes the analog front end supplies the comparator decision for the
 * current trial code and reads back the chosen inputs; the data lines are
 * resolved by the surroundings from bus_data_oe.
 */
`timescale 1ns/1ps
module mux_adc_host_interface
	import mux_adc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// host bus strobes
	input wire bus_ctl_t bus_ctl,
	// shared data lines, split
	input wire logic [7:0] bus_data_in,
	output logic [7:0] bus_data_out,
	output logic bus_data_oe,
	// done flag, active low
	output logic conversion_done_n,
	// analog front end
	input wire logic comparator_high,
	output logic [7:0] trial_code,
	output logic [2:0] mux_pos,
	output logic [2:0] mux_neg,
	output logic sampling
);
	// reset synchroniser
	logic rst_meta;
	logic rst_sync_n;

	// strobe history for edges
	logic wr_prev;
	// read held low through the whole write
	logic rd_low_all;
	// latched select nibble
	logic [3:0] sel;
	// output latch for the last finished code
	logic [7:0] result;
	// approximation register and bit under trial
	logic [7:0] sar;
	logic [7:0] sar_bit;
	// cycles within the current step
	logic [10:0] step_cnt;
	// sequencer state
	conv_state_t state;

	// decode a select nibble into a mux route
	function automatic mux_route_t decode_sel(input logic [3:0] s);
		mux_route_t r;
		r = '{pos: in_none, neg: in_none, valid: 1'b0};
		if (!s[2]) begin
			// differential, bit3 ignored
			if (!s[1]) begin
				r.pos = s[0] ? in_2 : in_1;
				r.neg = s[0] ? in_1 : in_2;
			end else begin
				r.pos = s[0] ? in_4 : in_3;
				r.neg = s[0] ? in_3 : in_4;
			end
			r.valid = 1'b1;
		end else if (!s[3]) begin
			// single ended against ground
			r.pos = 3'(s[1:0] + 2'h0) + in_1;
			r.neg = in_gnd;
			r.valid = 1'b1;
		end else if (s[1:0] != 2'h3) begin
			// pseudo differential
			r.pos = 3'(s[1:0]) + in_1;
			r.neg = in_4;
			r.valid = 1'b1;
		end
		return r;
	endfunction

	// decoded strobes
	wire logic wr_fall = wr_prev && !bus_ctl.wr_n;
	wire logic wr_rise = !wr_prev && bus_ctl.wr_n;
	// write edges count only with chip select low
	wire logic write_rise = wr_rise && !bus_ctl.cs_n;
	wire logic write_fall = wr_fall && !bus_ctl.cs_n;
	// host reading the result
	wire logic read_active = !bus_ctl.cs_n && !bus_ctl.rd_n;
	// select bits taken from the low data lines
	wire mux_route_t new_route = decode_sel(bus_data_in[3:0]);
	// load a valid select unless read was low through the whole write or at its release
	wire logic load_sel = write_rise && bus_ctl.rd_n && !rd_low_all && new_route.valid;
	// route currently applied to the mux
	wire mux_route_t cur_route = decode_sel(sel);
	// end of one approximation step
	wire logic step_done = (step_cnt == step_last);
	// keep or drop the bit under trial
	wire logic [7:0] next_sar = comparator_high ? sar : (sar & ~sar_bit);
	// last step of the last bit
	wire logic conv_end = (state == st_conv) && step_done && sar_bit[0];

	// release reset through two flops
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// strobe history and read-held tracking
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wr_prev <= 1'b1;
			rd_low_all <= 1'b0;
		end else begin
			wr_prev <= bus_ctl.wr_n;
			if (wr_fall) begin
				// read level at the start of the write
				rd_low_all <= !bus_ctl.rd_n;
			end else if (!bus_ctl.wr_n && bus_ctl.rd_n) begin
				// read seen high during the low period
				rd_low_all <= 1'b0;
			end
		end
	end

	// configuration latch
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sel <= sel_reset;
		end else if (load_sel) begin
			sel <= bus_data_in[3:0];
		end
	end

	// conversion sequencer
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= st_idle;
			sar <= trial_start;
			sar_bit <= trial_start;
			step_cnt <= 11'h000;
		end else begin
			case (state)
				st_idle: begin
					// waits for a write to arm
					if (write_fall) begin
						state <= st_arm;
					end
				end
				st_arm: begin
					// wait for write release
					if (write_rise) begin
						state <= st_conv;
						sar <= trial_start;
						sar_bit <= trial_start;
						step_cnt <= 11'h000;
					end
				end
				st_conv: begin
					if (write_fall) begin
						// a new write restarts the sequence
						state <= st_arm;
					end else if (step_done) begin
						// one binary step per slot
						step_cnt <= 11'h000;
						sar_bit <= sar_bit >> 1;
						sar <= next_sar | (sar_bit >> 1);
						if (sar_bit[0]) begin
							state <= st_idle;
						end
					end else begin
						// count through the step
						step_cnt <= step_cnt + 11'h001;
					end
				end
				default: begin
					// illegal code recovers to idle
					state <= st_idle;
				end
			endcase
		end
	end

	// result latch and done flag
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			result <= result_reset;
			conversion_done_n <= 1'b1;
		end else begin
			// latch the final code
			if (conv_end) begin
				result <= next_sar;
			end
			// completion wins over a clearing strobe
			if (conv_end) begin
				conversion_done_n <= 1'b0;
			end else if (write_fall || read_active) begin
				conversion_done_n <= 1'b1;
			end
		end
	end

	// registered bus and analog outputs
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			bus_data_out <= result_reset;
			bus_data_oe <= 1'b0;
			trial_code <= trial_start;
			mux_pos <= in_none;
			mux_neg <= in_none;
			sampling <= 1'b0;
		end else begin
			// data and enable trail the strobes by one cycle
			bus_data_out <= conv_end && read_active ? next_sar : result;
			bus_data_oe <= read_active;
			// front end sees the trial code and the route
			trial_code <= sar;
			mux_pos <= cur_route.pos;
			mux_neg <= cur_route.neg;
			sampling <= (state == st_conv);
		end
	end
endmodule

// [design/mux_adc_pkg.sv]
/*
 * constants and carrier types for the multiplexed converter host interface.
 * assumes a single 40 MHz clock; all bus inputs arrive synchronous to it.
 */
// Function
// - select bits share low data lines
// - conversion starts only by write pulse
// - write falling edge raises done line
// - write rising edge latches select, starts
// - read low during write keeps configuration
// - conversion end latches result, done low
// - chip select and read drive result
// - done stays low until read or write
// - negative difference gives all zeros code
// - bit2 low differential, bit1 picks pair
// - bit0 swaps differential pair polarity
// - single ended against analog ground
// - pseudo differential referenced to input four
// - unsigned eight bit code, 256 steps
package mux_adc_pkg;
	localparam int clock_mhz = 40;
	localparam int conv_time_us = 40;
	// longest time rounds down
	localparam int conv_cycles = conv_time_us * clock_mhz;
	localparam int read_wait_ns = 600;
	localparam int read_wait_cycles = (read_wait_ns * clock_mhz + 999) / 1000;
	localparam int data_width = 8;
	localparam int sel_width = 4;
	localparam int sar_steps = 8;
	// cycles per successive approximation step
	localparam int step_cycles = conv_cycles / sar_steps;
	localparam logic [10:0] step_last = 11'(step_cycles - 1);
	localparam logic [7:0] result_reset = 8'h00;
	localparam logic [3:0] sel_reset = 4'h4;
	// first trial code and first bit under trial of a conversion
	localparam logic [7:0] trial_start = 8'h80;

	// analog input index codes for the mux
	localparam logic [2:0] in_none = 3'h0;
	localparam logic [2:0] in_1 = 3'h1;
	localparam logic [2:0] in_2 = 3'h2;
	localparam logic [2:0] in_3 = 3'h3;
	localparam logic [2:0] in_4 = 3'h4;
	localparam logic [2:0] in_gnd = 3'h5;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_arm = 3'b010,
		st_conv = 3'b100
	} conv_state_t;

	// decoded mux assignment
	typedef struct packed {
		logic [2:0] pos;
		logic [2:0] neg;
		logic valid;
	} mux_route_t;

	// host bus strobes, all active low
	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} bus_ctl_t;
endpackage

// [verification/mux_adc_host_interface_asserts.sv]
/* timing checks on the converter host interface ports
   assumes binding onto the design top module */
`timescale 1ns/1ps
module mux_adc_host_interface_asserts
	import mux_adc_pkg::*;
(
	// clock, reset, strobes
	input wire logic clock,
	input wire logic nrst,
	input wire bus_ctl_t bus_ctl,
	// data lines
	input wire logic [7:0] bus_data_in,
	input wire logic [7:0] bus_data_out,
	input wire logic bus_data_oe,
	// done flag
	input wire logic conversion_done_n,
	// analog front end
	input wire logic comparator_high,
	input wire logic [7:0] trial_code,
	input wire logic [2:0] mux_pos,
	input wire logic [2:0] mux_neg,
	input wire logic sampling
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// host reading the result
	wire rd_sel = !bus_ctl.cs_n && !bus_ctl.rd_n;
	property p_oe; bus_data_oe == $past(rd_sel); endproperty
	a_oe: assert property (p_oe) else $error("oe lag");
	property p_rd; rd_sel |=> conversion_done_n; endproperty
	a_rd: assert property (p_rd) else $error("read");
	property p_wr; !bus_ctl.cs_n && $fell(bus_ctl.wr_n) |=> conversion_done_n; endproperty
	a_wr: assert property (p_wr) else $error("wr fall");
	property p_hold; !conversion_done_n && bus_ctl.cs_n |=> !conversion_done_n; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	// cycles spent converting, held at its top value
	logic [10:0] conv_age;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			conv_age <= 11'h000;
		end else if (!sampling) begin
			conv_age <= 11'h000;
		end else if (conv_age != 11'h7FF) begin
			conv_age <= conv_age + 11'h001;
		end
	end
	property p_conv; $fell(conversion_done_n) |-> int'(conv_age) == conv_cycles - 1; endproperty
	a_conv: assert property (p_conv) else $error("conv time");
	property p_conv_max; sampling |-> int'(conv_age) < conv_cycles; endproperty
	a_conv_max: assert property (p_conv_max) else $error("conv too long");
	property p_route; sampling && $past(sampling) |-> $stable({mux_pos, mux_neg}); endproperty
	a_route: assert property (p_route) else $error("route");
	property p_step; sampling && $changed(trial_code) |=> $stable(trial_code)[*8]; endproperty
	a_step: assert property (p_step) else $error("step");
	property p_start; !bus_ctl.cs_n && $rose(bus_ctl.wr_n) |-> ##[1:3] sampling; endproperty
	a_start: assert property (p_start) else $error("start");
endmodule
bind mux_adc_host_interface mux_adc_host_interface_asserts chk_u (
	.clock(clock),
	.nrst(nrst),
	.bus_ctl(bus_ctl),
	.bus_data_in(bus_data_in),
	.bus_data_out(bus_data_out),
	.bus_data_oe(bus_data_oe),
	.conversion_done_n(conversion_done_n),
	.comparator_high(comparator_high),
	.trial_code(trial_code),
	.mux_pos(mux_pos),
	.mux_neg(mux_neg),
	.sampling(sampling)
);

// [verification/mux_adc_host_model.sv]
/* host bus model: write and read cycles
   assumes a free running clock */
`timescale 1ns/1ps
module mux_adc_host_model
	import mux_adc_pkg::*;
(
	input wire logic clock,
	input wire logic [7:0] bus_data_out,
	input wire logic bus_data_oe,
	output bus_ctl_t bus_ctl,
	output logic [7:0] bus_data_in
);
	// idle bus
	initial begin
		bus_ctl = 3'b111;
		bus_data_in = 8'h00;
	end
	// step n edges, then drive
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	// write pulse, select on low lines
	task automatic wr(logic [3:0] sel, logic rd_low);
		cyc(1);
		bus_ctl = {1'b0, 1'b0, ~rd_low};
		bus_data_in = {4'h0, sel};
		cyc(6);
		bus_ctl.wr_n = 1'b1;
		cyc(2);
		bus_ctl = 3'b111;
		bus_data_in = ~bus_data_in;
	endtask
	// read after the settle wait
	task automatic rd(output logic [7:0] d);
		cyc(24);
		bus_ctl = 3'b010;
		cyc(2);
		d = bus_data_oe === 1'b1 ? bus_data_out : 8'hXX;
		bus_ctl = 3'b111;
	endtask
endmodule

// [verification/mux_adc_host_interface_tb_top.sv]
/* testbench: every mux mode, retained setting
   assumes host model and checker */
`timescale 1ns/1ps
module mux_adc_host_interface_tb_top
	import mux_adc_pkg::*;
;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	bus_ctl_t bus_ctl;
	logic [7:0] bus_data_in, bus_data_out, trial_code, rd_data;
	logic bus_data_oe, conversion_done_n, sampling;
	logic [2:0] mux_pos, mux_neg;
	int bad_count = 0;
	int n_tests = 0;
	// code of the last finished conversion
	logic [7:0] last_data = 8'h00;
	// input levels by mux code, index 0 unused, ground reads 0
	int ain [5] = '{0, 200, 50, 120, 30};
	// rd low, select, pos, neg
	logic [10:0] rows [13] = '{11'h00A, 11'h251, 11'h09C, 11'h2E3, 11'h10D, 11'h155,
		11'h19D, 11'h1E5, 11'h30C, 11'h354, 11'h39C, 11'h3DC, 11'h41C};
	always #12.5 clock = ~clock;
	function automatic int lvl(logic [2:0] i);
		return (i inside {[1:4]}) ? ain[i] : 0;
	endfunction
	// ideal comparator on the routed inputs
	wire comparator_high = lvl(mux_pos) - lvl(mux_neg) >= int'(trial_code);
	mux_adc_host_interface dut_u (
		.clock(clock),
		.nrst(nrst),
		.bus_ctl(bus_ctl),
		.bus_data_in(bus_data_in),
		.bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe),
		.conversion_done_n(conversion_done_n),
		.comparator_high(comparator_high),
		.trial_code(trial_code),
		.mux_pos(mux_pos),
		.mux_neg(mux_neg),
		.sampling(sampling)
	);
	mux_adc_host_model host_u (
		.clock(clock),
		.bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe),
		.bus_ctl(bus_ctl),
		.bus_data_in(bus_data_in)
	);
	task automatic complete_run();
		if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// one write, convert, read
	task automatic conv(logic [10:0] r);
		int e;
		int i;
		logic [7:0] x;
		e = lvl(r[5:3]) - lvl(r[2:0]);
		x = e < 0 ? 8'h00 : 8'(e);
		host_u.wr(r[9:6], r[10]);
		chk("done_wr", {7'h00, conversion_done_n}, 8'h01);
		chk("sampling", {7'h00, sampling}, 8'h01);
		// read held low through the write shows the old code
		if (r[10]) begin
			chk("oe_wr", {7'h00, bus_data_oe}, 8'h01);
			chk("data_wr", bus_data_out, last_data);
		end
		for (i = 0; i < 2000 && conversion_done_n !== 1'b0; i++) host_u.cyc(1);
		if (i == 2000) begin
			chk("done_low", {7'h00, conversion_done_n}, 8'h00);
			complete_run();
		end
		chk("route", {2'h0, mux_pos, mux_neg}, {2'h0, r[5:0]});
		chk("oe_idle", {7'h00, bus_data_oe}, 8'h00);
		host_u.cyc(24);
		chk("done_hold", {7'h00, conversion_done_n}, 8'h00);
		chk("sampling_end", {7'h00, sampling}, 8'h00);
		chk("trial", trial_code, x);
		host_u.rd(rd_data);
		chk("data", rd_data, x);
		chk("done_rd", {7'h00, conversion_done_n}, 8'h01);
		last_data = x;
	endtask
	task automatic t_modes();
		for (int k = 0; k < 11; k++) conv(rows[k]);
	endtask
	// undefined select, then read during write
	task automatic t_keep();
		conv(rows[11]);
		conv(rows[12]);
	endtask
	// write during a running conversion restarts it
	task automatic t_restart();
		host_u.wr(rows[0][9:6], 1'b0);
		host_u.cyc(300);
		conv(rows[2]);
	endtask
	initial begin
		host_u.cyc(4);
		nrst = 1'b1;
		host_u.cyc(4);
		t_modes();
		t_keep();
		t_restart();
		complete_run();
	end
endmodule
